// ==== verilog/bdr_pkg.sv ====
// Constants for the bus decode and reset-jump board logic
package bdr_pkg;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 8;
    localparam int          WIN_SEL_W      = 3;
    localparam logic [2:0]  WIN_SEL_DEF    = 3'h2;
    localparam int          WIN_OFF_W      = 12;
    localparam int          LOW1K_HI       = 11;
    localparam int          LOW1K_LO       = 10;
    localparam logic [1:0]  LOW1K_SLICE    = 2'h0;
    localparam logic        PROM_SEL       = 1'h0;
    localparam logic [11:0] RAM_BASE_OFF   = 12'h800;
    localparam int          RAM_DEPTH      = 256;
    localparam int          RAM_AW         = 8;
    localparam int          PROM_DEPTH     = 2048;
    localparam int          PROM_AW        = 11;
    localparam int          JUMP_BYTES     = 3;
    localparam logic [1:0]  JUMP_CNT_RESET = 2'h0;
    localparam logic [7:0]  JUMP_OPCODE    = 8'hc3;
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          CLK_NS         = 1_000_000_000 / CLK_HZ;
    localparam int          PROM_ACC_NS    = 650;
    localparam int          PROM_WAIT_CYC  = (PROM_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int          WAIT_W         = 5;
endpackage

// ==== verilog/bdr_mem.sv ====
// Byte-wide RAM with registered read data
`timescale 1ns/1ns
module bdr_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          ref_clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    initial begin
        if (DEPTH > (1 << AW)) begin
            $error("bdr_mem depth exceeds address width");
        end
    end

    logic [7:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// ==== verilog/bdr_top.sv ====
// Memory and port decode, PROM wait states, monitor RAM and reset-jump
`timescale 1ns/1ns
// Contract
// - Jumpers on A14..A12 pick base, A15 high
// - Default base D000, only bit-13 jumper fitted
// - Board answers a 4 KB memory window
// - Sixteen ports share high digit of base
// - Board inserts own wait states for PROM
// - 256 bytes RAM inside the window
// - 2 KB monitor PROM inside the window
// - Reset-jump arms while reset low, substitutes fetches after release
// - Static strap enables or disables reset-jump
// - First fetch forced to jump opcode, next two from monitor PROM bytes 1 and 2
// - Disarm only by access in first 1 KB
// - Cycles qualified by bus strobes, 20 MHz clock
module bdr_top #(
    parameter logic [7:0] JUMP_LO = 8'h03,
    parameter int         WAIT_CYC = bdr_pkg::PROM_WAIT_CYC
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    input  wire logic                        bus_reset_b,
    input  wire logic                        jump_strap_en,
    input  wire logic [bdr_pkg::WIN_SEL_W-1:0] jumper_fitted,
    input  wire logic [bdr_pkg::ADDR_W-1:0]  bus_addr,
    input  wire logic [bdr_pkg::DATA_W-1:0]  bus_dout,
    input  wire logic                        bus_psync,
    input  wire logic                        bus_pdbin,
    input  wire logic                        bus_pwr_b,
    input  wire logic                        bus_sinp,
    input  wire logic                        bus_sout,
    input  wire logic [bdr_pkg::DATA_W-1:0]  prom_rdata,
    input  wire logic [bdr_pkg::DATA_W-1:0]  port_rdata,
    output logic      [bdr_pkg::DATA_W-1:0]  bus_din,
    output logic                             bus_din_oe,
    output logic                             bus_rdy_b,
    output logic      [bdr_pkg::PROM_AW-1:0] prom_addr,
    output logic                             prom_cs,
    output logic      [3:0]                  port_num,
    output logic                             port_rd,
    output logic                             port_wr,
    output logic      [bdr_pkg::DATA_W-1:0]  port_wdata,
    output logic                             jump_armed
);
    initial begin
        if (WAIT_CYC < 1 || WAIT_CYC >= (1 << bdr_pkg::WAIT_W)) begin
            $error("bdr_top wait count out of range");
        end
    end

    typedef enum logic [1:0] {
        BDR_IDLE = 2'b00,
        BDR_WAIT = 2'b01,
        BDR_DATA = 2'b10
    } bdr_state_t;

    typedef struct packed {
        logic [bdr_pkg::ADDR_W-1:0] addr_s1;
        logic [bdr_pkg::ADDR_W-1:0] addr;
        logic [5:0]                 ctl_s1;
        logic [5:0]                 ctl;
        logic [bdr_pkg::DATA_W-1:0] dout_s1;
        logic [bdr_pkg::DATA_W-1:0] dout;
        logic [2:0]                 rst_s;
        logic [3:0]                 strap_s1;
        logic [3:0]                 strap_s2;
        logic                       strap_en;
        logic [bdr_pkg::WIN_SEL_W-1:0] base_sel;
        logic                       pwr_prev;
        logic                       psync_prev;
        logic                       armed;
        logic [1:0]                 jump_cnt;
        bdr_state_t                 state;
        logic [bdr_pkg::WAIT_W-1:0] wait_cnt;
        logic                       sel_ram;
        logic                       sub_read;
        logic [1:0]                 sub_idx;
        logic [bdr_pkg::DATA_W-1:0] din;
        logic                       din_oe;
        logic                       rdy_b;
        logic [bdr_pkg::PROM_AW-1:0] prom_addr;
        logic                       prom_cs;
        logic [3:0]                 port_num;
        logic                       port_rd;
        logic                       port_wr;
        logic [bdr_pkg::DATA_W-1:0] port_wdata;
    } bdr_regs_t;

    bdr_regs_t r;
    bdr_regs_t next_r;

    logic [bdr_pkg::DATA_W-1:0] ram_rdata;
    logic                       ram_we;
    logic [bdr_pkg::RAM_AW-1:0] ram_addr;

    // Synchronised bus fields
    logic psync_q, pdbin_q, pwr_q, sinp_q, sout_q, bus_rst_q;
    assign psync_q   = r.ctl[0];
    assign pdbin_q   = r.ctl[1];
    assign pwr_q     = ~r.ctl[2];
    assign sinp_q    = r.ctl[3];
    assign sout_q    = r.ctl[4];
    assign bus_rst_q = ~r.ctl[5];

    logic [3:0] base_hi;
    logic       mem_hit, io_hit, low1k, prom_hit, ram_hit, substitute;
    logic [11:0] off;

    always_comb begin
        base_hi = {1'b1, ~r.base_sel};
        off = r.addr[bdr_pkg::WIN_OFF_W-1:0];
        mem_hit = !sinp_q && !sout_q
                  && r.addr[bdr_pkg::ADDR_W-1:bdr_pkg::WIN_OFF_W] == base_hi;
        io_hit = (sinp_q || sout_q) && r.addr[7:4] == base_hi;
        prom_hit = mem_hit && off[bdr_pkg::LOW1K_HI] == bdr_pkg::PROM_SEL;
        ram_hit = mem_hit && off[11:bdr_pkg::RAM_AW] == bdr_pkg::RAM_BASE_OFF[11:8];
        low1k = mem_hit && off[bdr_pkg::LOW1K_HI:bdr_pkg::LOW1K_LO] == bdr_pkg::LOW1K_SLICE;
        substitute = r.armed && r.jump_cnt < 2'(bdr_pkg::JUMP_BYTES) && pdbin_q
                     && !sinp_q && !sout_q;
    end

    assign ram_addr = r.addr[bdr_pkg::RAM_AW-1:0];
    assign ram_we   = ram_hit && pwr_q && !r.pwr_prev;

    always_comb begin
        next_r = r;
        next_r.addr_s1 = bus_addr;
        next_r.addr    = r.addr_s1;
        next_r.ctl_s1  = {bus_reset_b, bus_sout, bus_sinp, bus_pwr_b, bus_pdbin, bus_psync};
        next_r.ctl     = r.ctl_s1;
        next_r.dout_s1 = bus_dout;
        next_r.dout    = r.dout_s1;
        next_r.rst_s   = {r.rst_s[1:0], 1'b1};
        next_r.strap_s1 = {jump_strap_en, jumper_fitted};
        next_r.strap_s2 = r.strap_s1;
        next_r.pwr_prev = pwr_q;
        next_r.psync_prev = psync_q;
        next_r.port_rd = 1'b0;
        next_r.port_wr = 1'b0;
        next_r.port_wdata = r.dout;
        // Straps taken once their synchroniser has filled after release
        if (r.rst_s == 3'b011) begin
            next_r.strap_en = r.strap_s2[bdr_pkg::WIN_SEL_W];
            next_r.base_sel = r.strap_s2[bdr_pkg::WIN_SEL_W-1:0];
        end
        if (bus_rst_q && r.strap_en) begin
            next_r.armed    = 1'b1;
            next_r.jump_cnt = bdr_pkg::JUMP_CNT_RESET;
        end else if (r.armed && psync_q && !sinp_q && !sout_q && low1k
                     && r.jump_cnt >= 2'(bdr_pkg::JUMP_BYTES)) begin
            next_r.armed = 1'b0;
        end
        case (r.state)
            BDR_IDLE: begin
                next_r.din_oe = 1'b0;
                next_r.rdy_b  = 1'b0;
                // One request per rising status strobe, which spans many clocks
                if (psync_q && !r.psync_prev && !bus_rst_q) begin
                    if (substitute || (prom_hit && pdbin_q)) begin
                        next_r.state     = BDR_WAIT;
                        next_r.wait_cnt  = bdr_pkg::WAIT_W'(WAIT_CYC);
                        next_r.rdy_b     = 1'b1;
                        next_r.prom_cs   = 1'b1;
                        next_r.sel_ram   = 1'b0;
                        next_r.sub_read  = substitute;
                        next_r.sub_idx   = r.jump_cnt;
                        next_r.prom_addr = substitute ? bdr_pkg::PROM_AW'(r.jump_cnt)
                                                      : off[bdr_pkg::PROM_AW-1:0];
                    end else if (ram_hit && pdbin_q) begin
                        next_r.state   = BDR_DATA;
                        next_r.sel_ram = 1'b1;
                    end else if (io_hit) begin
                        next_r.port_num = r.addr[3:0];
                        next_r.port_rd  = sinp_q;
                        next_r.port_wr  = sout_q;
                        if (sinp_q) begin
                            next_r.state   = BDR_DATA;
                            next_r.sel_ram = 1'b0;
                        end
                    end
                end
            end
            BDR_WAIT: begin
                next_r.wait_cnt = r.wait_cnt - 1'b1;
                if (r.wait_cnt == 1) begin
                    next_r.state = BDR_DATA;
                    next_r.rdy_b = 1'b0;
                end
            end
            BDR_DATA: begin
                next_r.din_oe = 1'b1;
                if (r.prom_cs) begin
                    if (r.sub_read && r.sub_idx == bdr_pkg::JUMP_CNT_RESET) begin
                        next_r.din = bdr_pkg::JUMP_OPCODE;
                    end else begin
                        next_r.din = prom_rdata;
                    end
                end else if (r.sel_ram) begin
                    next_r.din = ram_rdata;
                end else begin
                    next_r.din = port_rdata;
                end
                if (!pdbin_q) begin
                    next_r.state   = BDR_IDLE;
                    next_r.din_oe  = 1'b0;
                    next_r.prom_cs = 1'b0;
                    if (r.sub_read) begin
                        next_r.jump_cnt = r.jump_cnt + 1'b1;
                        next_r.sub_read = 1'b0;
                    end
                end
            end
            default: begin
                next_r.state = BDR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            r <= '0;
            r.ctl_s1 <= 6'h24;
            r.ctl    <= 6'h24;
            r.base_sel <= bdr_pkg::WIN_SEL_DEF;
            r.state  <= BDR_IDLE;
        end else begin
            r <= next_r;
        end
    end

    bdr_mem #(
        .DEPTH (bdr_pkg::RAM_DEPTH),
        .AW    (bdr_pkg::RAM_AW)
    ) u_ram (
        .ref_clk (ref_clk),
        .we      (ram_we),
        .addr    (ram_addr),
        .wdata   (r.dout),
        .rdata   (ram_rdata)
    );

    assign bus_din    = r.din;
    assign bus_din_oe = r.din_oe;
    assign bus_rdy_b  = r.rdy_b;
    assign prom_addr  = r.prom_addr;
    assign prom_cs    = r.prom_cs;
    assign port_num   = r.port_num;
    assign port_rd    = r.port_rd;
    assign port_wr    = r.port_wr;
    assign port_wdata = r.port_wdata;
    assign jump_armed = r.armed;

    sequence s_wait_start;
        r.state == BDR_IDLE && next_r.state == BDR_WAIT;
    endsequence

    sequence s_wait_hold;
        bus_rdy_b [*8] ##[1:16] !bus_rdy_b;
    endsequence

    property p_wait_len;
        @(posedge ref_clk) disable iff (!rst_b)
        s_wait_start |=> s_wait_hold;
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("PROM wait too short");

    property p_no_disarm_outside;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.armed && !low1k && !bus_rst_q) |=> r.armed;
    endproperty
    a_no_disarm_outside: assert property (p_no_disarm_outside) else $error("False disarm");

    property p_arm_on_reset;
        @(posedge ref_clk) disable iff (!rst_b)
        (bus_rst_q && r.strap_en) |=> r.armed && r.jump_cnt == 2'h0;
    endproperty
    a_arm_on_reset: assert property (p_arm_on_reset) else $error("Not armed in reset");

    property p_strap_off;
        @(posedge ref_clk) disable iff (!rst_b)
        (!r.strap_en && !r.armed) |=> !r.armed;
    endproperty
    a_strap_off: assert property (p_strap_off) else $error("Armed while strapped off");

    property p_opcode;
        @(posedge ref_clk) disable iff (!rst_b)
        (r.state == BDR_DATA && r.sub_read && r.sub_idx == 2'h0) |=>
            bus_din == bdr_pkg::JUMP_OPCODE;
    endproperty
    a_opcode: assert property (p_opcode) else $error("Jump opcode missing");

    property p_io_decode;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(port_wr) |-> port_num == $past(r.addr[3:0]);
    endproperty
    a_io_decode: assert property (p_io_decode) else $error("Bad port number");

    property p_mem_io_excl;
        @(posedge ref_clk) disable iff (!rst_b)
        !(mem_hit && io_hit);
    endproperty
    a_mem_io_excl: assert property (p_mem_io_excl) else $error("Both decodes hit");

    property p_ram_write;
        @(posedge ref_clk) disable iff (!rst_b)
        ram_we |-> ram_hit && !sinp_q && !sout_q;
    endproperty
    a_ram_write: assert property (p_ram_write) else $error("Stray RAM write");
endmodule

// ==== tb/bdr_cpu_model.sv ====
// Processor bus master model facing the board logic
`timescale 1ns/1ns
module bdr_cpu_model (
    input  wire logic        ref_clk,
    input  wire logic        bus_rdy_b,
    input  wire logic        bus_din_oe,
    output logic      [15:0] bus_addr,
    output logic      [7:0]  bus_dout,
    output logic             bus_psync,
    output logic             bus_pdbin,
    output logic             bus_pwr_b,
    output logic             bus_sinp,
    output logic             bus_sout
);
    // No jump logic of its own on this side of the bus
    initial begin
        bus_addr  = 16'h0000;
        bus_dout  = 8'h00;
        bus_psync = 1'b0;
        bus_pdbin = 1'b0;
        bus_pwr_b = 1'b1;
        bus_sinp  = 1'b0;
        bus_sout  = 1'b0;
    end

    // Kind: 0 mem read, 1 mem write, 2 port read, 3 port write
    task automatic cyc(input logic [1:0] kind, input logic [15:0] addr,
                       input logic [7:0] data, output logic [7:0] waits);
        int   n;
        logic rd;
        rd    = !kind[0];
        n     = 0;
        waits = 8'h00;
        @(negedge ref_clk);
        bus_addr  = addr;
        bus_dout  = data;
        bus_sinp  = (kind == 2'h2);
        bus_sout  = (kind == 2'h3);
        bus_pdbin = rd;
        bus_pwr_b = rd;
        bus_psync = 1'b1;
        // Status strobe drops after three clocks; others held until read data is driven, or eight clocks on writes
        while (n < 100 && !(rd ? bus_din_oe === 1'b1 : n >= 8)) begin
            @(negedge ref_clk);
            n++;
            if (n == 3) bus_psync = 1'b0;
            if (bus_rdy_b === 1'b1) waits++;
        end
        if (n >= 100) waits = 8'hff;
        @(negedge ref_clk);
        bus_psync = 1'b0;
        bus_pdbin = 1'b0;
        bus_pwr_b = 1'b1;
        bus_sinp  = 1'b0;
        bus_sout  = 1'b0;
        // Released data lines never keep the last value
        bus_dout  = ~bus_dout;
        repeat (6) @(negedge ref_clk);
    endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the bus decode and reset-jump logic
`timescale 1ns/1ns
module tb;
    localparam logic [7:0] PW = 8'((650 + 49) / 50);
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        bus_reset_b = 1'b1;
    logic        jump_strap_en = 1'b0;
    logic [2:0]  jumper_fitted = 3'h0;
    logic [7:0]  port_rdata = 8'h00;
    logic [7:0]  prom_rdata;
    logic [15:0] bus_addr;
    logic [7:0]  bus_dout, bus_din, port_wdata, w;
    logic        bus_psync, bus_pdbin, bus_pwr_b, bus_sinp, bus_sout;
    logic        bus_din_oe, bus_rdy_b, prom_cs, port_rd, port_wr, jump_armed;
    logic [10:0] prom_addr;
    logic [3:0]  port_num;
    logic [15:0] rnd = 16'h5588;
    logic        oe_q = 1'b0;
    logic [7:0]  rd_q[$];
    logic [11:0] pw_q[$];
    logic [3:0]  pr_q[$];
    int          miscompares = 0;
    int          n_tests = 0;

    always #25 ref_clk = ~ref_clk;

    // PROM stand-in: pattern from address, inverted while deselected
    assign prom_rdata = prom_cs ? (prom_addr[7:0] ^ 8'h5a) : ~(prom_addr[7:0] ^ 8'h5a);

    bdr_cpu_model i_bdr_cpu_model (.ref_clk(ref_clk), .bus_rdy_b(bus_rdy_b),
        .bus_din_oe(bus_din_oe), .bus_addr(bus_addr), .bus_dout(bus_dout),
        .bus_psync(bus_psync), .bus_pdbin(bus_pdbin), .bus_pwr_b(bus_pwr_b),
        .bus_sinp(bus_sinp), .bus_sout(bus_sout));

    bdr_top i_bdr_top (.ref_clk(ref_clk), .rst_b(rst_b), .bus_reset_b(bus_reset_b),
        .jump_strap_en(jump_strap_en), .jumper_fitted(jumper_fitted), .bus_addr(bus_addr),
        .bus_dout(bus_dout), .bus_psync(bus_psync), .bus_pdbin(bus_pdbin),
        .bus_pwr_b(bus_pwr_b), .bus_sinp(bus_sinp), .bus_sout(bus_sout),
        .prom_rdata(prom_rdata), .port_rdata(port_rdata), .bus_din(bus_din),
        .bus_din_oe(bus_din_oe), .bus_rdy_b(bus_rdy_b), .prom_addr(prom_addr),
        .prom_cs(prom_cs), .port_num(port_num), .port_rd(port_rd), .port_wr(port_wr),
        .port_wdata(port_wdata), .jump_armed(jump_armed));

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_port(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [2:0] j, input logic s);
        @(negedge ref_clk);
        rst_b         = 1'b0;
        jumper_fitted = j;
        jump_strap_en = s;
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        bus_reset_b = 1'b0;
        repeat (8) @(negedge ref_clk);
        bus_reset_b = 1'b1;
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic rd(input logic [1:0] k, input logic [15:0] a, input logic [7:0] exp,
                      input logic [7:0] wexp);
        rd_q.push_back(exp);
        i_bdr_cpu_model.cyc(k, a, 8'h00, w);
        cmp_data(w, wexp);
    endtask

    task automatic wr(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        i_bdr_cpu_model.cyc(k, a, d, w);
        cmp_data(w, 8'h00);
    endtask

    // Result watcher: read data on data-enable rise, port strobes
    always @(posedge ref_clk) begin
        oe_q <= bus_din_oe;
        if (bus_din_oe === 1'b1 && oe_q !== 1'b1) begin
            if (rd_q.size() == 0) cmp_data(8'h00, 8'hff);
            else cmp_data(bus_din, rd_q.pop_front());
        end
        if (port_wr === 1'b1) begin
            if (pw_q.size() == 0) cmp_port(12'h000, 12'hfff);
            else cmp_port({port_num, port_wdata}, pw_q.pop_front());
        end
        if (port_rd === 1'b1) begin
            if (pr_q.size() == 0) cmp_port(12'h000, 12'hfff);
            else cmp_port({port_num, 8'h00}, {pr_q.pop_front(), 8'h00});
        end
    end

    initial begin
        do_reset(3'h2, 1'b1);
        cmp_data({7'h0, jump_armed}, 8'h01);
        rd(2'h0, rnd, 8'hc3, PW);
        rnd = lfsr(rnd);
        rd(2'h0, rnd, 8'h5b, PW);
        rnd = lfsr(rnd);
        rd(2'h0, rnd, 8'h58, PW);
        rd(2'h0, 16'hd405, 8'h5f, PW);
        cmp_data({7'h0, jump_armed}, 8'h01);
        rd(2'h0, 16'hd003, 8'h59, PW);
        cmp_data({7'h0, jump_armed}, 8'h00);
        rnd = lfsr(rnd);
        wr(2'h1, 16'hd800, rnd[7:0]);
        wr(2'h1, 16'hd8ff, rnd[15:8]);
        rd(2'h0, 16'hd800, rnd[7:0], 8'h00);
        rd(2'h0, 16'hd8ff, rnd[15:8], 8'h00);
        port_rdata = rnd[7:0] ^ 8'h3c;
        pr_q.push_back(4'h5);
        rd(2'h2, 16'hd5d5, rnd[7:0] ^ 8'h3c, 8'h00);
        wr(2'h3, 16'he5e5, rnd[15:8]);
        pw_q.push_back({4'h0, rnd[15:8]});
        wr(2'h3, 16'hd0d0, rnd[15:8]);
        for (int j = 0; j < 8; j++) begin
            rnd = lfsr(rnd);
            do_reset(3'(j), 1'b0);
            cmp_data({7'h0, jump_armed}, 8'h00);
            rd(2'h0, {1'b1, ~3'(j), 12'h405}, 8'h5f, PW);
            pw_q.push_back({4'hf, rnd[7:0]});
            wr(2'h3, {2{1'b1, ~3'(j), 4'hf}}, rnd[7:0]);
        end
        cmp_data(8'(rd_q.size() + pw_q.size() + pr_q.size()), 8'h00);
        final_report;
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        miscompares++;
        final_report;
    end
endmodule
